/* File: src/twp_glitch_filter.sv */
// two-flop synchroniser and stability filter for bus and strap pins
`timescale 1ns/1ps
module twp_glitch_filter import twp_pkg::*; #(
  parameter int WIDTH = 1,
  parameter int STABLE_CYCLES = FILTER_CYCLES_DEF,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // pins
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] clean
);

  localparam int CNT_W = $clog2(STABLE_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STABLE_CYCLES - 1);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic [1:0] sync;
      logic [CNT_W-1:0] cnt;

      always_ff @(posedge clk) begin
        if (!reset_n) begin
          sync <= {2{INIT[i]}};
        end else begin
          sync <= {sync[0], raw[i]};
        end
      end

      // a new level must hold for the whole window before it is taken
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          cnt <= '0;
          clean[i] <= INIT[i];
        end else if (sync[1] == clean[i]) begin
          cnt <= '0;
        end else if (cnt == CNT_LAST) begin
          cnt <= '0;
          clean[i] <= sync[1];
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  endgenerate

endmodule // twp_glitch_filter

/* File: src/twp_pkg.sv */
// shared constants and types of the two-wire potentiometer slave
package twp_pkg;

  // system clock
  localparam int CLK_PERIOD_NS = 8;

  // non-volatile programming time after the closing stop
  localparam int NV_PROGRAM_TIME_MS = 5;
  localparam int NV_PROGRAM_CYCLES_DEF = NV_PROGRAM_TIME_MS * 1000000 / CLK_PERIOD_NS;

  // noise rejection on the bus inputs (least time, rounded up)
  localparam int FILTER_TIME_NS = 200;
  localparam int FILTER_CYCLES_DEF = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // wiper update limit after an instruction (longest time, rounded down)
  localparam int WIPER_SETTLE_TIME_NS = 10000;
  localparam int WIPER_SETTLE_CYCLES = WIPER_SETTLE_TIME_NS / CLK_PERIOD_NS;

  // byte framing
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [1:0] INSTR_IDX = 2'h0;
  localparam logic [1:0] DATA_IDX = 2'h1;
  localparam logic RW_READ = 1'b1;

  // opcodes that touch non-volatile data registers
  localparam logic [3:0] OP_WRITE_DR = 4'hc;
  localparam logic [3:0] OP_XFR_WCR_DR = 4'he;
  localparam logic [3:0] OP_GANG_WCR_DR = 4'h8;

  // pins as seen through the input filter
  typedef struct packed {
    logic [3:0] addr_sel;
    logic wp_n;
    logic sda;
    logic scl;
  } twp_pins_type;

  localparam int PIN_COUNT = $bits(twp_pins_type);
  localparam logic [PIN_COUNT-1:0] PIN_IDLE = 7'h7f;

  // command handed to the potentiometer core
  typedef struct packed {
    logic [3:0] opcode;
    logic [1:0] reg_sel;
    logic [1:0] pot_sel;
    logic [7:0] data;
    logic has_data;
  } twp_cmd_type;

endpackage

/* File: src/twp_slave.sv */
// two-wire serial slave engine of the dual potentiometer
`timescale 1ns/1ps
// Behaviour
// - ignore the bus until a start, data falling while clock high
// - data rising while clock high is a stop; master ends every operation so
// - first byte is the address; upper nibble must match the type code
// - lower address nibble must equal the four address-select pins
// - acknowledge the address byte only when it matches
// - the receiver pulls data low during the ninth clock
// - when addressed for write, acknowledge every received byte
// - read: send eight bits, sample master ack, continue or wait for stop
// - instruction is opcode nibble, two register bits, two pot bits
// - stop after a non-volatile write starts the programming cycle
// - while programming, data stays released and nothing is answered
// - programming lasts no longer than its maximum time
// - polling address is not acknowledged while busy, acknowledged after
// - the command reaches the core well within the wiper update time
// - start, stop and clock-fall detection reject pulses shorter than the noise window; bits are sampled on the raw link clock
// - write-protect low withholds the data acknowledge and programming for OP_WRITE_DR only
module twp_slave import twp_pkg::*; #(
  parameter logic [3:0] DEVICE_TYPE = 4'ha, // arbitrary type code
  parameter int NV_PROGRAM_CYCLES = NV_PROGRAM_CYCLES_DEF,
  parameter int FILTER_CYCLES = FILTER_CYCLES_DEF
) (
  // system
  input wire logic sys_clk,
  input wire logic reset_n,
  // link clock and data pin
  input wire logic scl_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // straps
  input wire logic [3:0] addr_select,
  input wire logic wp_n,
  // potentiometer core
  output twp_cmd_type cmd,
  output logic cmd_valid,
  input wire logic [7:0] rd_data,
  output logic rd_strobe,
  output logic nv_busy
);

  typedef enum {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_WAIT_STOP
  } twp_state_type;

  localparam int PROG_W = $clog2(NV_PROGRAM_CYCLES + 1);
  localparam logic [PROG_W-1:0] PROG_LAST = PROG_W'(NV_PROGRAM_CYCLES - 1);

  function automatic logic nv_trigger(input logic [3:0] op, input logic is_data);
    nv_trigger = (op == OP_WRITE_DR && is_data) ||
                 ((op == OP_XFR_WCR_DR || op == OP_GANG_WCR_DR) && !is_data);
  endfunction

  twp_state_type state;
  logic [3:0] bit_cnt;
  logic [7:0] shift, tx_shift;
  logic [1:0] byte_idx;
  logic rw_bit, master_ack, nv_armed;
  logic [PROG_W-1:0] prog_cnt;

  // link domain: sample data on every rising bus clock
  logic link_bit = 1'b0;
  logic link_toggle = 1'b0;

  always_ff @(posedge scl_clk) begin
    link_bit <= sda_in;
    link_toggle <= ~link_toggle;
  end

  // toggle crossing; the sampled bit is stable long before the toggle lands
  logic [1:0] tgl_sync;
  logic tgl_seen, bit_event;

  always_ff @(posedge sys_clk) begin
    tgl_sync <= {tgl_sync[0], link_toggle};
    tgl_seen <= tgl_sync[1];
  end

  assign bit_event = reset_n && (tgl_sync[1] != tgl_seen);

  // filtered pins
  twp_pins_type pins_raw;
  twp_pins_type pins;

  assign pins_raw = '{addr_sel: addr_select, wp_n: wp_n, sda: sda_in, scl: scl_clk};

  twp_glitch_filter #(
    .WIDTH(PIN_COUNT),
    .STABLE_CYCLES(FILTER_CYCLES),
    .INIT(PIN_IDLE)
  ) u_filter (
    .clk(sys_clk),
    .reset_n(reset_n),
    .raw(pins_raw),
    .clean(pins)
  );

  // bus conditions
  logic scl_q, sda_q;
  logic start_det, stop_det, scl_fall, live;
  logic byte_done, addr_match, wp_block, rx_accept;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= pins.scl;
      sda_q <= pins.sda;
    end
  end

  assign start_det = scl_q && pins.scl && sda_q && !pins.sda;
  assign stop_det = scl_q && pins.scl && !sda_q && pins.sda;
  assign scl_fall = scl_q && !pins.scl;
  assign live = !nv_busy && !stop_det && !start_det;
  assign byte_done = scl_fall && bit_cnt == BYTE_BITS;
  assign addr_match = shift[7:4] == DEVICE_TYPE && shift[3:0] == pins.addr_sel;
  assign wp_block = !pins.wp_n && byte_idx == DATA_IDX && cmd.opcode == OP_WRITE_DR;
  assign rx_accept = live && state == ST_RX && byte_done && !wp_block;

  // protocol sequencing
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      bit_cnt <= '0;
      shift <= '0;
      rw_bit <= 1'b0;
    end else if (nv_busy) begin
      state <= ST_IDLE;
      bit_cnt <= '0;
    end else if (stop_det) begin
      state <= ST_IDLE;
      bit_cnt <= '0;
    end else if (start_det) begin
      state <= ST_ADDR;
      bit_cnt <= '0;
    end else begin
      if (bit_event && bit_cnt < BYTE_BITS &&
          (state == ST_ADDR || state == ST_RX || state == ST_TX)) begin
        bit_cnt <= bit_cnt + 1'b1;
        if (state != ST_TX) begin
          shift <= {shift[6:0], link_bit};
        end
      end
      case (state)
        ST_ADDR: begin
          if (byte_done) begin
            rw_bit <= shift[0];
            state <= addr_match ? ST_ADDR_ACK : ST_IDLE;
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            bit_cnt <= '0;
            state <= (rw_bit == RW_READ) ? ST_TX : ST_RX;
          end
        end
        ST_RX: begin
          if (byte_done) begin
            state <= wp_block ? ST_WAIT_STOP : ST_RX_ACK;
          end
        end
        ST_RX_ACK: begin
          if (scl_fall) begin
            bit_cnt <= '0;
            state <= ST_RX;
          end
        end
        ST_TX: begin
          if (byte_done) begin
            state <= ST_TX_ACK;
          end
        end
        ST_TX_ACK: begin
          if (scl_fall) begin
            bit_cnt <= '0;
            state <= master_ack ? ST_TX : ST_WAIT_STOP;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // master acknowledge after each sent byte
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      master_ack <= 1'b0;
    end else if (state == ST_TX && byte_done) begin
      master_ack <= 1'b0;
    end else if (state == ST_TX_ACK && bit_event) begin
      master_ack <= !link_bit;
    end
  end

  // data line drive; low enable pulls the line low
  assign sda_out = 1'b0;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sda_oe_n <= 1'b1;
      tx_shift <= '0;
      rd_strobe <= 1'b0;
    end else begin
      rd_strobe <= 1'b0;
      if (!live) begin
        sda_oe_n <= 1'b1;
      end else begin
        case (state)
          ST_ADDR: begin
            if (byte_done && addr_match) begin
              sda_oe_n <= 1'b0;
            end
          end
          ST_RX: begin
            if (byte_done && !wp_block) begin
              sda_oe_n <= 1'b0;
            end
          end
          ST_RX_ACK: begin
            if (scl_fall) begin
              sda_oe_n <= 1'b1;
            end
          end
          ST_ADDR_ACK, ST_TX_ACK: begin
            if (scl_fall) begin
              if ((state == ST_ADDR_ACK && rw_bit == RW_READ) ||
                  (state == ST_TX_ACK && master_ack)) begin
                tx_shift <= rd_data;
                sda_oe_n <= rd_data[7];
                rd_strobe <= 1'b1;
              end else begin
                sda_oe_n <= 1'b1;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt < BYTE_BITS) begin
                sda_oe_n <= tx_shift[6];
                tx_shift <= {tx_shift[6:0], 1'b0};
              end else begin
                sda_oe_n <= 1'b1;
              end
            end
          end
          default: begin
            sda_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end

  // instruction and data bytes to the core
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cmd <= '0;
      cmd_valid <= 1'b0;
      byte_idx <= INSTR_IDX;
    end else begin
      cmd_valid <= 1'b0;
      if (start_det) begin
        byte_idx <= INSTR_IDX;
      end else if (rx_accept) begin
        if (byte_idx == INSTR_IDX) begin
          cmd.opcode <= shift[7:4];
          cmd.reg_sel <= shift[3:2];
          cmd.pot_sel <= shift[1:0];
          cmd.has_data <= 1'b0;
          byte_idx <= DATA_IDX;
        end else begin
          cmd.data <= shift;
          cmd.has_data <= 1'b1;
        end
        cmd_valid <= 1'b1;
      end
    end
  end

  // non-volatile programming cycle
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      nv_armed <= 1'b0;
    end else if (start_det || stop_det) begin
      nv_armed <= 1'b0;
    end else if (rx_accept && nv_trigger(byte_idx == INSTR_IDX ? shift[7:4] : cmd.opcode,
                                         byte_idx != INSTR_IDX)) begin
      nv_armed <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      nv_busy <= 1'b0;
      prog_cnt <= '0;
    end else if (nv_busy) begin
      prog_cnt <= prog_cnt + 1'b1;
      if (prog_cnt == PROG_LAST) begin
        nv_busy <= 1'b0;
      end
    end else if (stop_det && nv_armed) begin
      nv_busy <= 1'b1;
      prog_cnt <= '0;
    end
  end

  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  logic [PROG_W:0] busy_len;

  always_ff @(posedge sys_clk) begin
    if (!reset_n || !nv_busy) begin
      busy_len <= '0;
    end else begin
      busy_len <= busy_len + 1'b1;
    end
  end

  start_needed_a: assert property (state == ST_IDLE && !start_det |=> state == ST_IDLE)
    else $error("left idle without a start");
  stop_idle_a: assert property (stop_det |=> state == ST_IDLE && sda_oe_n)
    else $error("stop did not return to idle");
  addr_ack_a: assert property (
    live && state == ST_ADDR && byte_done && addr_match |=> !sda_oe_n && state == ST_ADDR_ACK)
    else $error("matching address not acknowledged");
  addr_nack_a: assert property (
    live && state == ST_ADDR && byte_done && !addr_match |=> sda_oe_n && state == ST_IDLE)
    else $error("foreign address acknowledged");
  write_ack_a: assert property (rx_accept |=> !sda_oe_n && state == ST_RX_ACK)
    else $error("written byte not acknowledged");
  wp_nack_a: assert property (
    live && state == ST_RX && byte_done && wp_block |=> sda_oe_n && state == ST_WAIT_STOP)
    else $error("protected data byte acknowledged");
  read_nack_a: assert property (
    live && state == ST_TX_ACK && scl_fall && !master_ack |=> sda_oe_n ##1 state == ST_WAIT_STOP)
    else $error("transmission went on without master ack");
  nv_start_a: assert property (
    stop_det && nv_armed && !nv_busy |=> nv_busy && prog_cnt == '0)
    else $error("programming not started at stop");
  nv_limit_a: assert property (busy_len <= (PROG_W+1)'(NV_PROGRAM_CYCLES))
    else $error("programming cycle too long");
  busy_deaf_a: assert property (nv_busy |=> sda_oe_n && state == ST_IDLE)
    else $error("bus answered while programming");
  poll_nack_a: assert property (
    nv_busy && start_det |-> ##1 state == ST_IDLE ##1 sda_oe_n)
    else $error("poll acknowledged while busy");
  cmd_issue_a: assert property (
    rx_accept |=> cmd_valid &&
      (cmd.has_data ? cmd.data : {cmd.opcode, cmd.reg_sel, cmd.pot_sel}) == $past(shift))
    else $error("command not issued after byte");

  read_cover_c: cover property (state == ST_TX_ACK && scl_fall && master_ack);
  write_cover_c: cover property (cmd_valid && cmd.has_data);
  nv_cover_c: cover property ($fell(nv_busy));
  poll_cover_c: cover property (nv_busy && start_det);

endmodule // twp_slave

/* File: verification/testbench.sv */
// self-checking bench of the two-wire potentiometer slave
`timescale 1ns/1ps
module testbench;
  import twp_pkg::*;
  localparam logic [3:0] DEV_T = 4'hb; // arbitrary type code
  localparam int NV_CYC = 400;
  localparam logic [3:0] OPS[3] = '{OP_WRITE_DR, OP_XFR_WCR_DR, OP_GANG_WCR_DR};
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] addr_select = 4'h0;
  logic wp_n = 1'b1;
  logic [7:0] rd_data = 8'h00;
  logic scl_clk, sda_rel, sda_out, sda_oe_n, cmd_valid, rd_strobe, nv_busy;
  wire sda_in;
  twp_cmd_type cmd;
  twp_cmd_type cq[$];
  logic [7:0] rq[$];
  int fails = 0;
  int n_compared = 0;
  int busy_len = 0;
  logic [3:0] sel;
  logic a;

  always #4 sys_clk = ~sys_clk;
  // open-drain wire with pull-up
  assign sda_in = sda_rel & (sda_oe_n | sda_out);

  twp_bus_master twp_bus_master_i (.scl(scl_clk), .sda_rel(sda_rel), .sda_wire(sda_in));
  twp_slave #(.DEVICE_TYPE(DEV_T), .NV_PROGRAM_CYCLES(NV_CYC), .FILTER_CYCLES(2)) twp_slave_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .scl_clk(scl_clk), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_select(addr_select), .wp_n(wp_n),
    .cmd(cmd), .cmd_valid(cmd_valid), .rd_data(rd_data), .rd_strobe(rd_strobe),
    .nv_busy(nv_busy));

  // core side: log commands, busy length, serve fresh read bytes
  always @(posedge sys_clk) begin
    if (cmd_valid === 1'b1) cq.push_back(cmd);
    if (nv_busy === 1'b1) busy_len <= busy_len + 1;
    if (rd_strobe === 1'b1) begin
      rq.push_back(rd_data);
      rd_data <= 8'($urandom);
    end else if (!reset_n) begin
      rd_data <= 8'($urandom);
    end
  end

  task automatic check(input string what, input logic [16:0] exp, input logic [16:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic st();
    twp_bus_master_i.start();
  endtask

  task automatic sp();
    twp_bus_master_i.stop();
  endtask

  task automatic wb(input logic [7:0] d, output logic ack);
    twp_bus_master_i.wbyte(d, ack);
  endtask

  task automatic poll(output logic ack);
    st();
    wb({DEV_T, sel[3:1], 1'b0}, ack);
    sp();
  endtask

  task automatic wr(input logic [3:0] op, input logic wp_low);
    logic k;
    logic [7:0] ins, dat;
    logic nv, blk;
    int b0;
    ins = {op, 4'($urandom)};
    dat = 8'($urandom);
    blk = wp_low && op == 4'hc;
    nv = !wp_low && (op == 4'hc || op == 4'he || op == 4'h8);
    @(posedge sys_clk) wp_n <= ~wp_low;
    tick(10);
    cq.delete();
    b0 = busy_len;
    st();
    wb({DEV_T, sel[3:1], 1'b0}, k);
    check("address ack", 17'h0, 17'(k));
    wb(ins, k);
    check("instruction ack", 17'h0, 17'(k));
    wb(dat, k);
    check("data ack", 17'(blk), 17'(k));
    sp();
    tick(2);
    check("command count", blk ? 17'h1 : 17'h2, 17'(cq.size()));
    if (cq.size() > 0) check("instruction", {8'h0, ins, 1'b0}, {8'h0, cq[0][16:9], cq[0][0]});
    if (cq.size() > 1) check("data", {ins, dat, 1'b1}, cq[1]);
    check("busy", 17'(nv), 17'(nv_busy));
    if (nv) begin
      poll(k);
      check("busy poll ack", 17'h1, 17'(k));
      for (int i = 0; i < 1000 && nv_busy !== 1'b0; i++) tick(1);
      check("busy length", 17'(NV_CYC), 17'(busy_len - b0));
    end
    poll(k);
    check("poll ack", 17'h0, 17'(k));
    $display("test write op %h wp %0d done", op, wp_low);
  endtask

  task automatic rd();
    logic k;
    logic [7:0] got[4];
    rq.delete();
    // read flag is address bit0, so the strap follows it
    @(posedge sys_clk) addr_select <= {sel[3:1], 1'b1};
    tick(10);
    st();
    wb({DEV_T, sel[3:1], 1'b1}, k);
    check("read address ack", 17'h0, 17'(k));
    for (int i = 0; i < 4; i++) twp_bus_master_i.rbyte(i < 2 ? 1'b0 : 1'b1, got[i]);
    sp();
    tick(2);
    check("read count", 17'h3, 17'(rq.size()));
    for (int i = 0; i < 3 && i < rq.size(); i++) check("read byte", 17'(rq[i]), 17'(got[i]));
    check("released after nack", 17'hff, 17'(got[3]));
    $display("test read done");
  endtask

  initial begin
    void'($urandom(56));
    sel = {3'($urandom), 1'b0};
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    addr_select <= sel;
    tick(10);
    wb({DEV_T, sel[3:1], 1'b0}, a);
    check("no start ack", 17'h1, 17'(a));
    sp();
    $display("test no start done");
    cq.delete();
    for (int i = 0; i < 2; i++) begin
      st();
      wb(i == 0 ? {DEV_T ^ 4'h4, sel[3:1], 1'b0} : {DEV_T, sel[3:1] ^ 3'h4, 1'b0}, a);
      check("foreign address ack", 17'h1, 17'(a));
      wb(8'($urandom), a);
      check("foreign byte ack", 17'h1, 17'(a));
      sp();
    end
    check("foreign commands", 17'h0, 17'(cq.size()));
    $display("test foreign address done");
    wr(4'ha, 1'b0);
    foreach (OPS[i]) wr(OPS[i], 1'b0);
    wr(4'hc, 1'b1);
    rd();
    test_done();
  end

  initial begin
    #400000;
    fails++;
    test_done();
  end
endmodule // testbench

/* File: verification/twp_bus_master.sv */
// two-wire bus master model driving the link clock and data line
`timescale 1ns/1ps
module twp_bus_master (
  // bus pins
  output logic scl,
  output logic sda_rel,
  input wire logic sda_wire
);
  // link clock stands high between frames, data released to pull-up
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  task automatic start();
    #20 sda_rel = 1'b1;
    #60 scl = 1'b1;
    #200 sda_rel = 1'b0;
    #200 scl = 1'b0;
  endtask

  task automatic stop();
    #20 sda_rel = 1'b0;
    #60 scl = 1'b1;
    #200 sda_rel = 1'b1;
    #200;
  endtask

  // data moves only while clock is low; wire taken at the rising edge
  task automatic bit_io(input logic b, output logic s);
    #20 sda_rel = b;
    #60 scl = 1'b1;
    s = sda_wire;
    #45 scl = 1'b0;
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, ack);
  endtask

  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(mack, s);
  endtask
endmodule // twp_bus_master
